// ---- pkg/tih_pkg.sv ----
// Shared constants and types for the True IDE host port controller.
// Assumes a single 25 MHz clock and a synchronous active-low reset.

package tih_pkg;

  // ****************************************
  // Clock and cable timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 40;
  localparam int ADDR_SETUP_NS   = 70;
  localparam int STROBE_WIDTH_NS = 165;
  localparam int ADDR_HOLD_NS    = 20;
  localparam int DEV_RESET_NS    = 25000;

  // Least time to whole cycles, never under one
  function automatic int ns_to_cycles_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cycles_up

  localparam int SETUP_CYC = ns_to_cycles_up(ADDR_SETUP_NS);
  localparam int WIDTH_CYC = ns_to_cycles_up(STROBE_WIDTH_NS);
  localparam int HOLD_CYC  = ns_to_cycles_up(ADDR_HOLD_NS);
  localparam int RESET_CYC = ns_to_cycles_up(DEV_RESET_NS);

  // ****************************************
  // Widths and addresses
  // ****************************************
  localparam int         DATA_W        = 16;
  localparam int         FIFO_DEPTH    = 16;
  localparam int         PHASE_W       = 4;
  localparam int         RESET_W       = 10;
  localparam logic [2:0] DATA_REG_ADDR = 3'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    TIH_SPACE_TASK = 2'h0,
    TIH_SPACE_CTRL = 2'h1,
    TIH_SPACE_DATA = 2'h2
  } tih_space_e;

  typedef enum logic [1:0] {
    TIH_ST_IDLE   = 2'b00,
    TIH_ST_SETUP  = 2'b01,
    TIH_ST_STROBE = 2'b11,
    TIH_ST_HOLD   = 2'b10
  } tih_state_e;

  typedef struct packed {
    logic             write;
    tih_space_e       space;
    logic [2:0]       addr;
    logic [15:0]      wdata;
  } tih_cmd_s;

  typedef struct packed {
    logic irq;
    logic io_ready;
    logic word_cycle;
    logic activity;
    logic pass_diag;
    logic dma_request;
  } tih_status_s;

endpackage : tih_pkg

// ---- rtl/tih_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module tih_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // ****************************************
  // Storage
  // ****************************************
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // ****************************************
  // Pointers and fill level
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : tih_fifo

`default_nettype wire

// ---- rtl/tih_host.sv ----
// Host controller for a True IDE flash disk on a 40-pin cable.
// Assumes cable inputs are synchronous to clk; the cable wiring resolves
// two-way pins from the enables.
//
// How it works
// - No higher address line exists here, so all of them read as zero.
// - Task-file and data cycles use the first select, control the second.
// - The activity line is only sensed, so a second drive may use it.
// - The pass-diagnostic line is a two-way pin this host only senses.
`timescale 1ns/1ps
`default_nettype none

module tih_host (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // User side
  input  wire logic                 dev_reset_req,
  input  wire tih_pkg::tih_cmd_s    cmd,
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  output logic [15:0]               rsp_data,
  output logic                      rsp_valid,
  input  wire logic                 rsp_ready,
  output tih_pkg::tih_status_s      status,
  // Cable side
  output logic                      ide_reset_n,
  output logic [2:0]                ide_addr,
  output logic                      task_select_n,
  output logic                      control_select_n,
  output logic                      io_read_strobe_n,
  output logic                      io_write_strobe_n,
  output logic [15:0]               data_out,
  output logic [1:0]                data_oe,
  input  wire logic [15:0]          data_in,
  input  wire logic                 io_ready,
  input  wire logic                 irq,
  input  wire logic                 word_cycle_n,
  input  wire logic                 activity_present_n_in,
  output logic                      activity_present_n_out,
  output logic                      activity_present_n_oe,
  input  wire logic                 pass_diag_n_in,
  output logic                      pass_diag_n_out,
  output logic                      pass_diag_n_oe,
  input  wire logic                 dma_request,
  output logic                      dma_ack_n
);

  tih_pkg::tih_state_e                state;
  tih_pkg::tih_cmd_s                  cur;
  logic [tih_pkg::PHASE_W-1:0]        cnt;
  logic [tih_pkg::RESET_W-1:0]        rst_cnt;
  logic                               accept;
  logic                               active;
  logic                               is_word;
  logic                               strobe_end;
  logic                               fifo_in_ready;
  logic                               fifo_push;
  logic [15:0]                        next_rsp;

  // ****************************************
  // Command acceptance
  // ****************************************
  assign cmd_ready = (state == tih_pkg::TIH_ST_IDLE) && ide_reset_n
                     && !dev_reset_req && (cmd.write || fifo_in_ready);
  assign accept     = cmd_valid && cmd_ready;
  assign active     = (state != tih_pkg::TIH_ST_IDLE);
  assign is_word    = (cur.space == tih_pkg::TIH_SPACE_DATA);
  assign strobe_end = (state == tih_pkg::TIH_ST_STROBE) && (cnt == '0)
                      && io_ready;

  // ****************************************
  // Device reset pulse
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_cnt     <= tih_pkg::RESET_W'(tih_pkg::RESET_CYC);
      ide_reset_n <= 1'b0;
    end else if (dev_reset_req && !active) begin
      rst_cnt     <= tih_pkg::RESET_W'(tih_pkg::RESET_CYC);
      ide_reset_n <= 1'b0;
    end else if (rst_cnt != '0) begin
      rst_cnt <= rst_cnt - 1'b1;
      if (rst_cnt == tih_pkg::RESET_W'(1)) begin
        ide_reset_n <= 1'b1;
      end
    end
  end

  // ****************************************
  // Cycle sequencer
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= tih_pkg::TIH_ST_IDLE;
      cnt   <= '0;
    end else begin
      unique case (state)
        tih_pkg::TIH_ST_IDLE: begin
          if (accept) begin
            state <= tih_pkg::TIH_ST_SETUP;
            cnt   <= tih_pkg::PHASE_W'(tih_pkg::SETUP_CYC - 1);
          end
        end
        tih_pkg::TIH_ST_SETUP: begin
          if (cnt == '0) begin
            state <= tih_pkg::TIH_ST_STROBE;
            cnt   <= tih_pkg::PHASE_W'(tih_pkg::WIDTH_CYC - 1);
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        tih_pkg::TIH_ST_STROBE: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (io_ready) begin
            state <= tih_pkg::TIH_ST_HOLD;
            cnt   <= tih_pkg::PHASE_W'(tih_pkg::HOLD_CYC - 1);
          end
        end
        tih_pkg::TIH_ST_HOLD: begin
          if (cnt == '0) begin
            state <= tih_pkg::TIH_ST_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Latched command and write data
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur      <= '0;
      ide_addr <= '0;
      data_out <= '0;
    end else if (accept) begin
      cur <= cmd;
      if (cmd.space == tih_pkg::TIH_SPACE_DATA) begin
        ide_addr <= tih_pkg::DATA_REG_ADDR;
        data_out <= cmd.wdata;
      end else begin
        ide_addr <= cmd.addr;
        data_out <= {8'h00, cmd.wdata[7:0]};
      end
    end
  end

  // ****************************************
  // Cable strobes, selects and data enables
  // ****************************************
  // Gray states: each strobe edge changes one state bit only
  assign io_read_strobe_n  = !((state == tih_pkg::TIH_ST_STROBE)
                               && !cur.write);
  assign io_write_strobe_n = !((state == tih_pkg::TIH_ST_STROBE)
                               && cur.write);
  assign task_select_n     = !(active
                               && (cur.space != tih_pkg::TIH_SPACE_CTRL));
  assign control_select_n  = !(active
                               && (cur.space == tih_pkg::TIH_SPACE_CTRL));
  assign data_oe           = (active && cur.write)
                             ? {is_word, 1'b1} : 2'b00;

  // Host only senses these shared lines and holds dma_ack_n inactive high
  assign activity_present_n_out = 1'b1;
  assign activity_present_n_oe  = 1'b0;
  assign pass_diag_n_out        = 1'b1;
  assign pass_diag_n_oe         = 1'b0;
  assign dma_ack_n              = 1'b1;

  // ****************************************
  // Read capture into response FIFO
  // ****************************************
  assign fifo_push = strobe_end && !cur.write;
  assign next_rsp  = is_word ? {data_in[15:8], data_in[7:0]}
                             : {8'h00, data_in[7:0]};

  tih_fifo #(
    .WIDTH (tih_pkg::DATA_W),
    .DEPTH (tih_pkg::FIFO_DEPTH)
  ) u_rsp_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (next_rsp),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready),
    .out_data  (rsp_data)
  );

  // ****************************************
  // Sensed device status
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status.irq         <= irq;
      status.io_ready    <= io_ready;
      status.word_cycle  <= !word_cycle_n;
      status.activity    <= !activity_present_n_in;
      status.pass_diag   <= !pass_diag_n_in;
      status.dma_request <= dma_request;
    end
  end

endmodule : tih_host

`default_nettype wire

// ---- verif/tih_dev_model.sv ----
// Behavioural True IDE device facing the host port cable.
// Assumes the bench clock only to pace io_ready and idle bus noise.
`timescale 1ns/1ps
`default_nettype none
module tih_dev_model (
  input  wire logic        clk,
  input  wire logic        ide_reset_n,
  input  wire logic [2:0]  ide_addr,
  input  wire logic        task_select_n,
  input  wire logic        control_select_n,
  input  wire logic        io_read_strobe_n,
  input  wire logic        io_write_strobe_n,
  input  wire logic [15:0] data_out,
  input  wire logic [1:0]  data_oe,
  input  wire logic [3:0]  wait_cyc,
  input  wire logic [3:0]  pins,
  output logic      [15:0] data_in,
  output logic             io_ready,
  output logic             irq,
  output logic             word_cycle_n,
  output logic             activity_n,
  output logic             pass_diag_n,
  output logic             dma_request
);
  // ****************************************
  // Device side
  // ****************************************
  logic [7:0]  task_reg [8];
  logic [7:0]  ctrl;
  logic [15:0] word;
  logic [15:0] drv;
  logic [15:0] last = 16'h5a5a;
  logic [3:0]  width = 4'h0;
  logic [1:0]  lane;
  logic        one_sel;
  assign one_sel = task_select_n ^ control_select_n;
  assign irq = pins[0];
  assign dma_request = pins[1];
  assign pass_diag_n = !pins[2];
  assign activity_n = !(pins[3] || !io_read_strobe_n);
  assign word_cycle_n = !(!task_select_n && ide_addr == 3'h0);
  assign io_ready = width >= wait_cyc;
  always @(posedge clk) begin
    width <= (io_read_strobe_n && io_write_strobe_n) ? 4'h0 : width + 4'h1;
    last <= data_in;
  end
  always_comb begin
    lane = 2'h0;
    drv = {8'h00, task_reg[ide_addr]};
    if (one_sel && !io_read_strobe_n) begin
      lane = (!task_select_n && ide_addr == 3'h0) ? 2'h3
                                                  : 2'h1;
      if (lane[1]) drv = word;
      if (!control_select_n) drv = {8'h00, task_reg[7]};
    end
    for (int i = 0; i < 2; i++) begin
      if (data_oe[i]) data_in[i*8+:8] = data_out[i*8+:8];
      else if (lane[i]) data_in[i*8+:8] = io_ready ? drv[i*8+:8] : ~drv[i*8+:8];
      else data_in[i*8+:8] = ~last[i*8+:8];
    end
  end
  always @(posedge io_write_strobe_n or negedge ide_reset_n) begin
    if (!ide_reset_n) begin
      for (int i = 0; i < 8; i++) task_reg[i] = 8'h00;
      word = 16'h0000;
    end else if (one_sel && !task_select_n) begin
      if (ide_addr == 3'h0) word = data_in;
      else task_reg[ide_addr] = data_in[7:0];
    end else if (one_sel) ctrl = data_in[7:0];
  end
endmodule : tih_dev_model
`default_nettype wire

// ---- verif/tih_host_sva.sv ----
// Checker for the cable pins and status of the host port.
// Assumes it is bound into tih_host; one clock, rst_n active low.
`timescale 1ns/1ps
`default_nettype none
module tih_host_sva (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 ide_reset_n,
  input wire logic [2:0]           ide_addr,
  input wire logic                 task_select_n,
  input wire logic                 control_select_n,
  input wire logic                 io_read_strobe_n,
  input wire logic                 io_write_strobe_n,
  input wire logic [1:0]           data_oe,
  input wire logic                 io_ready,
  input wire logic                 irq,
  input wire tih_pkg::tih_status_s status
);
  // ****************************************
  // Cable checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_SEL_ONE: assert property (task_select_n || control_select_n)
    else $error("both selects low");
  AST_STB_SEL: assert property (
    !(io_read_strobe_n && io_write_strobe_n) |->
    task_select_n != control_select_n)
    else $error("strobe without one select");
  AST_WR_EDGE: assert property (
    $rose(io_write_strobe_n) |-> data_oe[0])
    else $error("write data gone at strobe rise");
  AST_WORD_ADDR: assert property (data_oe[1] |->
    (ide_addr == 3'h0 && !task_select_n)) else $error("high lane outside data");
  AST_RD_FREE: assert property (
    !io_read_strobe_n |-> data_oe == 2'h0)
    else $error("host drives bus in read");
  AST_STRETCH: assert property (!io_read_strobe_n && !io_ready |=>
    !io_read_strobe_n) else $error("strobe ended while not ready");
  AST_DEV_RST: assert property (
    disable iff (1'b0) !rst_n |=> !ide_reset_n)
    else $error("device reset not low");
  AST_IRQ: assert property (
    $past(rst_n) |-> status.irq == $past(irq))
    else $error("irq status wrong");
endmodule : tih_host_sva
bind tih_host tih_host_sva chk_u (.clk(clk), .rst_n(rst_n),
  .ide_reset_n(ide_reset_n), .ide_addr(ide_addr),
  .task_select_n(task_select_n),
  .control_select_n(control_select_n), .io_read_strobe_n(io_read_strobe_n),
  .io_write_strobe_n(io_write_strobe_n), .data_oe(data_oe),
  .io_ready(io_ready), .irq(irq), .status(status));
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the host port with a device model.
// Assumes tih_host, tih_fifo and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************************************
  // Bench
  // ****************************************
  logic clk = 1'b0, rst_n = 1'b0, dev_reset_req = 1'b0, cmd_valid = 1'b0;
  logic rsp_ready = 1'b0, cmd_ready, rsp_valid, ide_reset_n, task_select_n;
  logic control_select_n, io_read_strobe_n, io_write_strobe_n, io_ready, irq;
  logic word_cycle_n, act_in, act_out, act_oe, act_dev, pd_in, pd_out, pd_oe;
  logic pd_dev, dma_request, dma_ack_n;
  logic [15:0] rsp_data, data_out, data_in;
  logic [2:0] ide_addr;
  logic [1:0] data_oe;
  logic [3:0] wait_cyc = 4'h0, pins = 4'h0;
  tih_pkg::tih_cmd_s cmd = '0;
  tih_pkg::tih_status_s status;
  int err_total = 0, tests_run = 0;
  assign act_in = act_oe ? act_out : act_dev;
  assign pd_in = pd_oe ? pd_out : pd_dev;
  always #20 clk = ~clk;
  tih_host dut_u (.clk(clk), .rst_n(rst_n), .dev_reset_req(dev_reset_req),
    .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .status(status), .ide_reset_n(ide_reset_n), .ide_addr(ide_addr),
    .task_select_n(task_select_n), .control_select_n(control_select_n),
    .io_read_strobe_n(io_read_strobe_n), .io_write_strobe_n(io_write_strobe_n),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
    .io_ready(io_ready), .irq(irq), .word_cycle_n(word_cycle_n),
    .activity_present_n_in(act_in), .activity_present_n_out(act_out),
    .activity_present_n_oe(act_oe), .pass_diag_n_in(pd_in),
    .pass_diag_n_out(pd_out), .pass_diag_n_oe(pd_oe),
    .dma_request(dma_request), .dma_ack_n(dma_ack_n));
  tih_dev_model dev_u (.clk(clk), .ide_reset_n(ide_reset_n),
    .ide_addr(ide_addr), .task_select_n(task_select_n),
    .control_select_n(control_select_n), .io_read_strobe_n(io_read_strobe_n),
    .io_write_strobe_n(io_write_strobe_n), .data_out(data_out),
    .data_oe(data_oe), .wait_cyc(wait_cyc), .pins(pins), .data_in(data_in),
    .io_ready(io_ready), .irq(irq), .word_cycle_n(word_cycle_n),
    .activity_n(act_dev), .pass_diag_n(pd_dev), .dma_request(dma_request));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic issue(input logic w, input logic [1:0] sp,
                       input logic [2:0] a, input logic [15:0] d);
    int n = 0;
    @(negedge clk);
    cmd = '{w, tih_pkg::tih_space_e'(sp), a, d};
    cmd_valid = 1'b1;
    #1;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check(16'(n < 2000), 16'h0001);
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : issue
  task automatic pop(output logic [15:0] v);
    int n = 0;
    @(negedge clk);
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check(16'(n < 2000), 16'h0001);
    v = rsp_data;
    rsp_ready = 1'b1;
    @(negedge clk);
    rsp_ready = 1'b0;
  endtask : pop
  task automatic rd(input logic [1:0] sp, input logic [2:0] a,
                    output logic [15:0] v);
    issue(1'b0, sp, a, 16'h0000);
    pop(v);
  endtask : rd
  task automatic t_task;
    logic [15:0] v;
    for (int i = 1; i < 8; i++) begin
      issue(1'b1, 2'h0, i[2:0], {8'hee, 8'h30 + i[7:0]});
    end
    for (int i = 1; i < 8; i++) begin
      rd(2'h0, i[2:0], v);
      check(v, {8'h00, 8'h30 + i[7:0]});
    end
  endtask : t_task
  task automatic t_ctrl_data;
    logic [15:0] v;
    issue(1'b1, 2'h1, 3'h6, 16'h0002);
    rd(2'h1, 3'h6, v);
    check(v, 16'h0037);
    check(dev_u.ctrl, 8'h02);
    check(dev_u.task_reg[6], 8'h36);
    issue(1'b1, 2'h2, 3'h0, 16'hb2c1);
    issue(1'b0, 2'h2, 3'h0, 16'h0000);
    @(negedge clk);
    check(16'(status.word_cycle), 16'h0001);
    pop(v);
    check(v, 16'hb2c1);
    check(dev_u.word[7:0], 8'hc1);
  endtask : t_ctrl_data
  task automatic t_fifo;
    logic [15:0] v;
    wait_cyc = 4'h8;
    rd(2'h0, 3'h2, v);
    check(v, 16'h0032);
    wait_cyc = 4'h3;
    for (int i = 0; i < 16; i++) issue(1'b0, 2'h0, 3'h5, 16'h0000);
    repeat (16) @(negedge clk);
    cmd = '{1'b0, tih_pkg::TIH_SPACE_TASK, 3'h5, 16'h0000};
    #1;
    check(cmd_ready, 1'b0);
    wait_cyc = 4'h0;
    for (int i = 0; i < 16; i++) begin
      pop(v);
      check(v, 16'h0035);
    end
    check(rsp_valid, 1'b0);
  endtask : t_fifo
  task automatic t_status;
    logic [15:0] v;
    pins = 4'hf;
    repeat (3) @(negedge clk);
    check(status, 6'b110111);
    pins = 4'h0;
    repeat (3) @(negedge clk);
    check(status, 6'b010000);
    check({13'h0000, act_oe, pd_oe, dma_ack_n}, 16'h0001);
    dev_reset_req = 1'b1;
    @(negedge clk);
    dev_reset_req = 1'b0;
    repeat (2) @(negedge clk);
    check(ide_reset_n, 1'b0);
    rd(2'h0, 3'h3, v);
    check(v, 16'h0000);
  endtask : t_status
  task automatic complete_run;
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_task;
    t_ctrl_data;
    t_fifo;
    t_status;
    complete_run;
  end
  initial begin
    #400000;
    err_total++;
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
